// >>> ebu_pkg.sv
// Constants and types for the external bus unit
package ebu_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [1:0] EBU_ADDR_CTRL_A = 2'h0;
    localparam logic [1:0] EBU_ADDR_CTRL_B = 2'h1;
    localparam logic [1:0] EBU_ADDR_STATUS = 2'h2;
    localparam logic [7:0] EBU_CTRL_A_RESET = 8'h00;
    localparam logic [7:0] EBU_CTRL_B_RESET = 8'h00;
    localparam logic [7:0] EBU_CTRL_B_MASK = 8'h87;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int EBU_ENABLE_BIT = 7;
    localparam int EBU_SRL_LSB = 4;
    localparam int EBU_UWAIT_LSB = 2;
    localparam int EBU_LWAIT_LSB = 0;
    localparam int EBU_KEEPER_BIT = 7;
    localparam int EBU_HMASK_LSB = 0;
    // ****************************************
    // Address map
    // ****************************************
    localparam logic [15:0] EBU_EXT_BASE = 16'h2200;
    localparam logic [2:0] EBU_HI_START_BASE = 3'h2;
    // ****************************************
    // Wait codes
    // ****************************************
    localparam logic [1:0] EBU_WAIT_NONE = 2'h0;
    localparam logic [1:0] EBU_WAIT_TWO_PLUS = 2'h3;
    // ****************************************
    // Sequencer states
    // ****************************************
    typedef enum logic [2:0] {
        EBU_IDLE,
        EBU_ADDR,
        EBU_STROBE,
        EBU_WAIT,
        EBU_HOLD,
        EBU_TRAIL
    } ebu_state_t;
endpackage

// >>> ebu_regfile.sv
// Small register store for the external bus unit control registers
`timescale 1ns/1ns
`default_nettype none
module ebu_regfile
    import ebu_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic [1:0] rd_addr,
    input wire logic [7:0] status_in,
    output logic [7:0] rd_data,
    output logic [7:0] ctrl_a,
    output logic [7:0] ctrl_b
);
    typedef struct packed {
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [7:0] rd_data;
    } ebu_rf_t;
    ebu_rf_t r;
    ebu_rf_t next_r;

    always_comb begin
        next_r = r;
        if (wr_en && wr_addr == EBU_ADDR_CTRL_A) begin
            next_r.ctrl_a = wr_data;
        end
        if (wr_en && wr_addr == EBU_ADDR_CTRL_B) begin
            next_r.ctrl_b = wr_data & EBU_CTRL_B_MASK;
        end
        unique case (rd_addr)
            EBU_ADDR_CTRL_A: next_r.rd_data = r.ctrl_a;
            EBU_ADDR_CTRL_B: next_r.rd_data = r.ctrl_b;
            EBU_ADDR_STATUS: next_r.rd_data = status_in;
            default: next_r.rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '{EBU_CTRL_A_RESET, EBU_CTRL_B_RESET, 8'h00};
        end else begin
            r <= next_r;
        end
    end

    assign rd_data = r.rd_data;
    assign ctrl_a = r.ctrl_a;
    assign ctrl_b = r.ctrl_b;
endmodule
`default_nettype wire

// >>> ebu_core.sv
// External bus unit: multiplexed external data-space bus sequencer
// Function
// - Shared low address/data lane, high address lines, latch, read, write strobes.
// - When enabled, bus pin directions come from the unit, not software.
// - Unit decides internal versus external per access and drives pins.
// - Low address valid on lane when latch strobe falls.
// - Latch strobe held low through the whole data phase.
// - Internal accesses may toggle address and latch, never read/write strobes.
// - Disabled unit returns pins to port control; no aliasing into internal SRAM.
// - Lane pull-ups enabled while lane is not driven and matching port output bits are one.
// - Keeper holds last driven lane value while lane is tri-stated.
// - Four wait settings, independent per lower and upper sector.
// - Trailing latch pulse only when next instruction accesses RAM.
// - Control bit 7 enables unit and switches pins to bus functions.
// - Sector limit in bits 6..4, reset zero; one sector uses upper wait.
// - Lower sector from 0x2200; codes 010..111 put upper start 0x4000..0xE000.
// - Bits 3..2 select upper sector wait states.
// - Wait code 0 none, 1 one, 2 two, 3 two plus one before address.
// - Bits 1..0 select lower sector wait states.
// - Keeper has its own enable, active even when unit disabled.
// - High address mask releases topmost high pins to port use.
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module ebu_core
    import ebu_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic acc_req,
    input wire logic acc_write,
    input wire logic [15:0] acc_addr,
    input wire logic [7:0] acc_wdata,
    input wire logic next_ram_access,
    output logic acc_external,
    output logic acc_done,
    output logic [7:0] acc_rdata,
    input wire logic [7:0] port_lane_out,
    input wire logic [7:0] port_lane_dir,
    input wire logic [7:0] port_high_out,
    input wire logic [7:0] port_high_dir,
    input wire logic [7:0] lane_in,
    output logic [7:0] lane_out,
    output logic [7:0] lane_oe,
    output logic [7:0] lane_pullup,
    output logic [7:0] lane_keeper,
    output logic [7:0] high_out,
    output logic [7:0] high_oe,
    output logic latch_strobe,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic strobe_oe
);
    // ****************************************
    // Register file
    // ****************************************
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] status;
    logic ext_bus_enable;
    logic [2:0] sector_limit_sel;
    logic [1:0] upper_wait;
    logic [1:0] lower_wait;
    logic bus_keeper_enable;
    logic [2:0] high_addr_release_mask;
    logic [1:0] rd_index;

    // Empty slot outside read strobes
    assign rd_index = reg_rd ? reg_addr : 2'h3;

    ebu_regfile ebu_regfile_i (
        .clk(clk),
        .rst(rst),
        .wr_addr(reg_addr),
        .wr_data(reg_wdata),
        .wr_en(reg_wr),
        .rd_addr(rd_index),
        .status_in(status),
        .rd_data(reg_rdata),
        .ctrl_a(ctrl_a),
        .ctrl_b(ctrl_b)
    );

    // ****************************************
    // Field decode
    // ****************************************
    // enable bit decode
    assign ext_bus_enable = ctrl_a[EBU_ENABLE_BIT];
    assign sector_limit_sel = ctrl_a[EBU_SRL_LSB +: 3];
    assign upper_wait = ctrl_a[EBU_UWAIT_LSB +: 2];
    assign lower_wait = ctrl_a[EBU_LWAIT_LSB +: 2];
    assign bus_keeper_enable = ctrl_b[EBU_KEEPER_BIT];
    assign high_addr_release_mask = ctrl_b[EBU_HMASK_LSB +: 3];

    // ****************************************
    // Sequencer state
    // ****************************************
    typedef struct packed {
        ebu_state_t state;
        logic [1:0] wait_cnt;
        logic hold_extra;
        logic external;
        logic write;
        logic trail;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic [7:0] lane_last;
        logic done;
        logic ext_flag;
        logic [7:0] lane_out;
        logic [7:0] lane_oe;
        logic [7:0] lane_pullup;
        logic [7:0] lane_keeper;
        logic [7:0] high_out;
        logic [7:0] high_oe;
        logic latch;
        logic rd_n;
        logic wr_n;
        logic strobe_oe;
    } ebu_core_t;
    ebu_core_t r;
    ebu_core_t next_r;

    logic is_ext;
    logic upper_sel;
    logic [1:0] wait_code;
    logic [15:0] upper_start;
    logic [7:0] high_keep;
    logic drive_rw;
    logic [1:0] wait_load;
    logic wait_post;
    logic trail_pulse;
    logic addr_phase;

    // ****************************************
    // Address decode
    // ****************************************
    always_comb begin
        upper_start = {sector_limit_sel - EBU_HI_START_BASE + 3'h2, 13'h0000};
        is_ext = ext_bus_enable && (acc_addr >= EBU_EXT_BASE);
        upper_sel = (sector_limit_sel[2:1] == 2'b00) || (acc_addr >= upper_start);
        wait_code = upper_sel ? upper_wait : lower_wait;
    end

    // ****************************************
    // High address pin release
    // ****************************************
    // release topmost high pins, code 7 frees all
    for (genvar g = 0; g < 8; g++) begin : g_keep
        assign high_keep[g] = (high_addr_release_mask != 3'h7)
            && (g < 8 - int'(high_addr_release_mask));
    end

    // ****************************************
    // Wait-state decode
    // ****************************************
    // wait code to strobe cycles
    always_comb begin
        unique case (wait_code)
            EBU_WAIT_NONE: begin
                wait_load = 2'h0;
                wait_post = 1'b0;
            end
            EBU_WAIT_TWO_PLUS: begin
                wait_load = 2'h2;
                wait_post = 1'b1;
            end
            default: begin
                wait_load = wait_code;
                wait_post = 1'b0;
            end
        endcase
    end

    // ****************************************
    // Sequencer and pin drive
    // ****************************************
    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        drive_rw = 1'b0;
        unique case (r.state)
            EBU_IDLE: begin
                if (acc_req) begin
                    next_r.addr = acc_addr;
                    next_r.wdata = acc_wdata;
                    next_r.write = acc_write;
                    next_r.external = is_ext;
                    next_r.ext_flag = is_ext;
                    next_r.trail = next_ram_access;
                    next_r.wait_cnt = wait_load;
                    next_r.hold_extra = is_ext && wait_post;
                    next_r.state = EBU_ADDR;
                end
            end
            EBU_ADDR: next_r.state = EBU_STROBE;
            EBU_STROBE: begin
                next_r.state = (r.external && r.wait_cnt != 2'h0) ? EBU_WAIT : EBU_HOLD;
            end
            EBU_WAIT: begin
                next_r.wait_cnt = r.wait_cnt - 2'h1;
                if (r.wait_cnt == 2'h1) begin
                    next_r.state = EBU_HOLD;
                end
            end
            EBU_HOLD: begin
                if (!r.write) begin
                    next_r.rdata = r.external ? lane_in : 8'h00;
                end
                next_r.done = 1'b1;
                next_r.state = r.hold_extra ? EBU_TRAIL : EBU_IDLE;
                next_r.hold_extra = 1'b0;
            end
            EBU_TRAIL: next_r.state = EBU_IDLE;
            default: next_r.state = EBU_IDLE;
        endcase

        // trailing pulse only if next RAM access
        trail_pulse = next_r.state == EBU_IDLE && r.state != EBU_IDLE && r.trail;
        addr_phase = next_r.state == EBU_ADDR || trail_pulse;
        // unit owns pin direction when enabled
        if (ext_bus_enable) begin
            // address on lane while latch high
            next_r.lane_out = addr_phase ? next_r.addr[7:0] : r.wdata;
            next_r.lane_oe = (addr_phase
                || (r.write && (next_r.state == EBU_STROBE || next_r.state == EBU_WAIT
                || next_r.state == EBU_HOLD))) ? 8'hff : 8'h00;
            for (int i = 0; i < 8; i++) begin
                next_r.high_out[i] = high_keep[i] ? next_r.addr[8 + i] : port_high_out[i];
                next_r.high_oe[i] = high_keep[i] ? 1'b1 : port_high_dir[i];
            end
            next_r.latch = addr_phase;
            drive_rw = r.external && (next_r.state == EBU_STROBE
                || next_r.state == EBU_WAIT || next_r.state == EBU_HOLD);
            next_r.strobe_oe = 1'b1;
        end else begin
            next_r.lane_out = port_lane_out;
            next_r.lane_oe = port_lane_dir;
            next_r.high_out = port_high_out;
            next_r.high_oe = port_high_dir;
            next_r.latch = 1'b0;
            next_r.strobe_oe = 1'b0;
        end
        next_r.rd_n = !(drive_rw && !r.write);
        next_r.wr_n = !(drive_rw && r.write);

        next_r.lane_pullup = port_lane_out & ~next_r.lane_oe;
        if (|r.lane_oe) begin
            next_r.lane_last = r.lane_out;
        end
        next_r.lane_keeper = bus_keeper_enable ? next_r.lane_last : 8'h00;
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
            r.state <= EBU_IDLE;
            r.rd_n <= 1'b1;
            r.wr_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // ****************************************
    // Status and outputs
    // ****************************************
    assign status = {5'h00, r.ext_flag, r.state != EBU_IDLE, ext_bus_enable};
    assign acc_external = r.ext_flag;
    assign acc_done = r.done;
    assign acc_rdata = r.rdata;
    assign lane_out = r.lane_out;
    assign lane_oe = r.lane_oe;
    assign lane_pullup = r.lane_pullup;
    assign lane_keeper = r.lane_keeper;
    assign high_out = r.high_out;
    assign high_oe = r.high_oe;
    assign latch_strobe = r.latch;
    assign read_strobe_n = r.rd_n;
    assign write_strobe_n = r.wr_n;
    assign strobe_oe = r.strobe_oe;
endmodule
`default_nettype wire

// >>> ebu_properties.sv
// Assertion checker for the external bus unit
`timescale 1ns/1ns
`default_nettype none
module ebu_properties (
    input wire logic clk,
    input wire logic rst,
    input wire logic acc_req,
    input wire logic next_ram_access,
    input wire logic acc_done,
    input wire logic acc_external,
    input wire logic [7:0] port_lane_dir,
    input wire logic [7:0] lane_oe,
    input wire logic latch_strobe,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic strobe_oe
);
    logic busy;
    logic nra_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            busy <= 1'b0;
            nra_q <= 1'b0;
        end else if (acc_req && !busy) begin
            busy <= 1'b1;
            nra_q <= next_ram_access;
        end else if (acc_done) begin
            busy <= 1'b0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_rd_ext; !read_strobe_n |-> acc_external && strobe_oe; endproperty
    property p_wr_ext; !write_strobe_n |-> acc_external && strobe_oe; endproperty
    property p_addr_fall; $fell(latch_strobe) && strobe_oe |-> $past(lane_oe) == 8'hff; endproperty
    property p_ale_low; !(read_strobe_n && write_strobe_n) |-> !latch_strobe; endproperty
    property p_port_dir;
        !strobe_oe && $past(strobe_oe) == 1'b0 && $past(rst) == 1'b0 && $stable(port_lane_dir)
            |-> lane_oe == port_lane_dir;
    endproperty
    property p_trail; acc_done && strobe_oe && nra_q |-> ##[0:1] latch_strobe; endproperty
    property p_no_trail; acc_done && strobe_oe && !nra_q |-> !latch_strobe; endproperty
    property p_done_min; acc_req && !busy |=> !acc_done [*3]; endproperty
    property p_done_max; acc_req && !busy |-> ##[4:6] acc_done; endproperty
    property p_rd_len; $fell(read_strobe_n) |-> !read_strobe_n [*2] ##[1:3] read_strobe_n; endproperty
    a_rd_ext: assert property (p_rd_ext) else $error("read strobe on internal access");
    a_wr_ext: assert property (p_wr_ext) else $error("write strobe on internal access");
    a_addr_fall: assert property (p_addr_fall) else $error("lane not driven at latch fall");
    a_ale_low: assert property (p_ale_low) else $error("latch high during strobe");
    a_port_dir: assert property (p_port_dir) else $error("lane direction not from port");
    a_trail: assert property (p_trail) else $error("trailing latch pulse wrong");
    a_no_trail: assert property (p_no_trail) else $error("unwanted trailing latch pulse");
    a_done_min: assert property (p_done_min) else $error("access ended too early");
    a_done_max: assert property (p_done_max) else $error("access ended too late");
    a_rd_len: assert property (p_rd_len) else $error("read strobe length wrong");
    c_ext: cover property (acc_done && acc_external);
    c_trail: cover property (acc_done && latch_strobe);
    c_write: cover property (!write_strobe_n);
endmodule
bind ebu_core ebu_properties ebu_properties_i (.clk, .rst, .acc_req, .next_ram_access,
    .acc_done, .acc_external, .port_lane_dir, .lane_oe, .latch_strobe, .read_strobe_n,
    .write_strobe_n, .strobe_oe);
`default_nettype wire

// >>> ebu_sram_model.sv
// External memory behind an address latch
`timescale 1ns/1ns
`default_nettype none
module ebu_sram_model (
    input wire logic clk,
    input wire logic [7:0] lane_out,
    input wire logic [7:0] high_out,
    input wire logic latch_strobe,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    output logic [7:0] mdl_data,
    output logic mdl_oe
);
    logic [7:0] mem [0:65535];
    logic [7:0] lo_q;
    logic [15:0] addr;
    assign addr = {high_out, lo_q};
    // latch closes on the falling strobe
    always @(posedge clk) begin
        if (latch_strobe) lo_q <= lane_out;
    end
    // Capture data while strobe low
    always @(posedge clk) begin
        if (!write_strobe_n) mem[addr] <= lane_out;
    end
    assign mdl_oe = !read_strobe_n;
    assign mdl_data = mem[addr];
endmodule
`default_nettype wire

// >>> ebu_core_bench.sv
// Self-checking bench for the external bus unit
`timescale 1ns/1ns
`default_nettype none
module ebu_core_bench;
    import ebu_pkg::*;
    logic clk, rst, reg_wr, reg_rd, acc_req, acc_write, next_ram_access, mdl_oe;
    logic acc_external, acc_done, latch_strobe, read_strobe_n, write_strobe_n, strobe_oe;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, acc_wdata, acc_rdata, lane_in, lane_out, lane_oe;
    logic [7:0] port_lane_out, port_lane_dir, port_high_out, port_high_dir, mdl_data;
    logic [7:0] lane_pullup, lane_keeper, high_out, high_oe, d, q, ca;
    logic [15:0] acc_addr, lat, a;
    int num_errors, n_checks, s, w, m;
    assign lane_in = (lane_oe & lane_out) | (~lane_oe & (mdl_oe ? mdl_data : ~lane_out));
    ebu_core ebu_core_i (.*);
    ebu_sram_model ebu_sram_model_i (.*);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [1:0] ad, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= ad;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [1:0] ad, output logic [7:0] v);
        @(posedge clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask
    task automatic acc(input logic [15:0] ad, input logic wr, input logic [7:0] v,
                       output logic [15:0] n, output logic [7:0] r);
        @(posedge clk);
        acc_addr <= ad;
        acc_write <= wr;
        acc_wdata <= v;
        next_ram_access <= 1'($urandom);
        acc_req <= 1'b1;
        @(posedge clk);
        acc_req <= 1'b0;
        n = 0;
        while (acc_done !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
            if (n > 16) begin
                num_errors++;
                end_of_test();
            end
        end
        r = acc_rdata;
        repeat (2) @(posedge clk);
        #1;
    endtask
    function automatic logic [15:0] exp_lat(input logic [7:0] c, input logic [15:0] ad);
        logic [1:0] wc;
        wc = (c[6:5] == 2'h0 || ad >= {c[6:4], 13'h0}) ? c[3:2] : c[1:0];
        return 16'h3 + ((wc == 2'h3) ? 16'h2 : {14'h0, wc});
    endfunction
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst = 1'b1;
        {reg_wr, reg_rd, acc_req, acc_write, next_ram_access} = 5'h0;
        {reg_addr, reg_wdata, acc_addr, acc_wdata} = 34'h0;
        {port_lane_out, port_lane_dir, port_high_out, port_high_dir} = 32'h0;
        void'($urandom(42));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (s = 0; s < 4; s++) begin
            rd_reg(2'(s), d);
            chk("reset_reg", {8'h0, d}, 16'h0);
        end
        for (s = 0; s < 8; s++) begin
            ca = 8'($urandom);
            wr_reg(EBU_ADDR_CTRL_B, ca);
            rd_reg(EBU_ADDR_CTRL_B, d);
            chk("ctrl_b", {8'h0, d}, {8'h0, ca & EBU_CTRL_B_MASK});
            wr_reg(2'h3, ca);
            rd_reg(2'h3, d);
            chk("unmapped", {8'h0, d}, 16'h0);
        end
        wr_reg(EBU_ADDR_CTRL_B, 8'h00);
        $display("test registers done");
        for (s = 0; s < 8; s++) begin
            for (w = 0; w < 4; w++) begin
                ca = {1'b1, s[2:0], w[1:0], 2'(3 - w)};
                wr_reg(EBU_ADDR_CTRL_A, ca);
                rd_reg(EBU_ADDR_CTRL_A, d);
                chk("ctrl_a", {8'h0, d}, {8'h0, ca});
                a = 16'h2200 + 16'($urandom % 32'hde00);
                if (s > 1 && w == 1) a = {s[2:0], 13'h0};
                if (s > 1 && w == 2) a = {s[2:0], 13'h0} - 16'h1;
                d = 8'($urandom);
                acc(a, 1'b1, d, lat, q);
                chk("wr_latency", lat, exp_lat(ca, a));
                chk("wr_ext", {15'h0, acc_external}, 16'h1);
                acc(a, 1'b0, 8'h0, lat, q);
                chk("rd_latency", lat, exp_lat(ca, a));
                chk("rd_data", {8'h0, q}, {8'h0, d});
            end
        end
        $display("test sectors done");
        wr_reg(EBU_ADDR_CTRL_B, 8'h80);
        acc(16'h5555, 1'b1, 8'ha5, lat, q);
        chk("keeper_on", {8'h0, lane_keeper}, {8'h0, next_ram_access ? 8'h55 : 8'ha5});
        wr_reg(EBU_ADDR_CTRL_B, 8'h00);
        @(posedge clk);
        #1;
        chk("keeper_off", {8'h0, lane_keeper}, 16'h0);
        port_high_dir <= 8'($urandom);
        port_lane_out <= 8'($urandom);
        port_high_out <= 8'($urandom);
        for (m = 0; m < 8; m++) begin
            wr_reg(EBU_ADDR_CTRL_B, 8'(m));
            repeat (2) @(posedge clk);
            #1;
            ca = (m == 7) ? 8'h00 : 8'hff >> m;
            chk("high_oe", {8'h0, high_oe}, {8'h0, ca | (port_high_dir & ~ca)});
            chk("high_out", {8'h0, high_out}, {8'h0, (8'h55 & ca) | (port_high_out & ~ca)});
            chk("pullup", {8'h0, lane_pullup}, {8'h0, port_lane_out});
        end
        $display("test keeper and mask done");
        port_lane_dir <= 8'($urandom);
        wr_reg(EBU_ADDR_CTRL_A, 8'h00);
        acc(16'h8000, 1'b0, 8'h0, lat, q);
        chk("dis_ext", {15'h0, acc_external}, 16'h0);
        chk("dis_rdata", {8'h0, q}, 16'h0);
        chk("dis_lane_oe", {8'h0, lane_oe}, {8'h0, port_lane_dir});
        chk("dis_high_oe", {8'h0, high_oe}, {8'h0, port_high_dir});
        wr_reg(EBU_ADDR_CTRL_A, 8'h80);
        acc(16'h21ff, 1'b1, 8'h3c, lat, q);
        chk("int_ext", {15'h0, acc_external}, 16'h0);
        rd_reg(EBU_ADDR_STATUS, d);
        chk("status", {8'h0, d}, 16'h0001);
        $display("test internal done");
        end_of_test();
    end
endmodule
`default_nettype wire
